// file: led_driver_fault_supervisor_tb.sv
// Self-checking bench for the fault supervisor
`timescale 1ns/1ps
module led_driver_fault_supervisor_tb;
    // ------------------------------------------------------------
    // Shortened counts
    // ------------------------------------------------------------
    localparam int OFF = 20;
    localparam int QT = 40;
    localparam int SD = 60;
    localparam int DG = 5;
    localparam int OT = 30;
    localparam int DC = 4;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic dimInput = 1'b0;
    logic dimmingMode = 1'b0;
    logic switchRequest = 1'b0;
    logic overcurrentTrip = 1'b0;
    logic feedbackOver = 1'b0;
    logic feedbackBelowClear = 1'b0;
    logic feedbackLow = 1'b0;
    logic overTemp = 1'b0;
    logic coolDown = 1'b0;
    logic faultReportNOut;
    logic faultReportNOe;
    logic highSideOn;
    logic ledEnable;
    logic faultWire;
    int n_mismatch = 0;
    int total_checks = 0;
    int cycles = 0;
    int seed;
    always #5 clk = ~clk;
    lfs_supervisor #(.OCP_OFF_CYC(OFF), .QUIET_CYC(QT), .SHUTDOWN_CYC(SD),
        .DEGLITCH_CYC(DG), .ONTIME_CYC(OT), .DIM_CYC(DC)) lfs_supervisor_i (
        .clk(clk), .sys_rst(sys_rst), .dimInput(dimInput), .dimmingMode(dimmingMode),
        .switchRequest(switchRequest), .overcurrentTrip(overcurrentTrip),
        .feedbackOver(feedbackOver), .feedbackBelowClear(feedbackBelowClear),
        .feedbackLow(feedbackLow), .overTemp(overTemp), .coolDown(coolDown),
        .faultReportNIn(faultWire), .faultReportNOut(faultReportNOut),
        .faultReportNOe(faultReportNOe), .highSideOn(highSideOn), .ledEnable(ledEnable));
    lfs_host_model lfs_host_model_i (.faultReportNOut(faultReportNOut),
        .faultReportNOe(faultReportNOe), .faultWire(faultWire));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic lineFor(input logic fault);
        return fault ? 1'b0 : 1'b1;
    endfunction : lineFor
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    task automatic check(input logic seen, input logic exp, input string msg);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s seen %b expected %b", $time, msg, seen, exp);
        end
    endtask : check
    task automatic fault(input logic f, input string msg);
        check(faultWire, lineFor(f), msg);
        check(faultReportNOut, 1'b0, "line never driven high");
    endtask : fault
    task automatic dimPulses(input int n);
        repeat (n)
        begin
            dimInput = 1'b0;
            tick($urandom_range(2, 6));
            dimInput = 1'b1;
            tick($urandom_range(2, 6));
        end
    endtask : dimPulses
    // Long low dim level forces shutdown; the next high is a fresh start
    task automatic restart;
        dimInput = 1'b0;
        tick(SD + 5);
        dimInput = 1'b1;
        tick(3);
    endtask : restart
    // ------------------------------------------------------------
    // Hang guard
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            give_verdict();
        end
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial
    begin
        seed = $urandom(32'had16);
        tick(10);
        sys_rst = 1'b0;
        tick(1);
        check(faultReportNOe, 1'b0, "reset oe");
        check(highSideOn, 1'b0, "reset switch");
        dimInput = 1'b1;
        tick(3);
        check(ledEnable, 1'b1, "led on");
        // Free switching follows the request one cycle later
        repeat (60)
        begin
            switchRequest = 1'($urandom_range(0, 1));
            tick(1);
            check(highSideOn, switchRequest, "switch track");
            fault(1'b0, "idle line");
        end
        switchRequest = 1'b1;
        tick(2);
        overcurrentTrip = 1'b1;
        tick(1);
        check(highSideOn, 1'b0, "ocp off");
        overcurrentTrip = 1'b0;
        tick(OFF - 3);
        check(highSideOn, 1'b0, "ocp hold");
        tick(6);
        check(highSideOn, 1'b1, "ocp retry");
        fault(1'b0, "first trip");
        overcurrentTrip = 1'b1;
        tick(1);
        check(highSideOn, 1'b0, "second trip off");
        overcurrentTrip = 1'b0;
        tick(1);
        fault(1'b1, "second trip");
        tick(QT - 10);
        fault(1'b1, "ocp quiet early");
        tick(15);
        fault(1'b0, "ocp quiet done");
        feedbackOver = 1'b1;
        tick(1);
        check(highSideOn, 1'b0, "ovp off");
        fault(1'b1, "ovp line");
        // The string enable is registered from the latched fault, one cycle behind
        tick(1);
        check(ledEnable, 1'b0, "ovp led");
        feedbackOver = 1'b0;
        tick(QT + 5);
        fault(1'b1, "ovp not cleared");
        check(highSideOn, 1'b1, "ovp retry");
        feedbackBelowClear = 1'b1;
        tick(QT - 10);
        fault(1'b1, "ovp clear early");
        tick(15);
        fault(1'b0, "ovp clear done");
        check(ledEnable, 1'b1, "ovp led back");
        overTemp = 1'b1;
        tick(1);
        fault(1'b1, "hot line");
        check(highSideOn, 1'b0, "hot switch");
        tick(1);
        check(ledEnable, 1'b0, "hot led");
        overTemp = 1'b0;
        tick(20);
        fault(1'b1, "no cool yet");
        check(ledEnable, 1'b0, "stays off");
        coolDown = 1'b1;
        tick(2);
        fault(1'b0, "cooled");
        check(ledEnable, 1'b1, "restarted");
        coolDown = 1'b0;
        feedbackLow = 1'b1;
        tick(QT - 5);
        feedbackLow = 1'b0;
        tick(1);
        feedbackLow = 1'b1;
        tick(QT - 5);
        fault(1'b0, "open timer restart");
        tick(10);
        fault(1'b1, "open undimmed");
        check(ledEnable, 1'b0, "open led");
        feedbackLow = 1'b0;
        tick(QT - 10);
        fault(1'b1, "open clear early");
        tick(15);
        fault(1'b0, "open clear done");
        dimmingMode = 1'b1;
        switchRequest = 1'b0;
        feedbackLow = 1'b1;
        tick(DG + 3);
        dimPulses(DC - 2);
        fault(1'b0, "few dim cycles");
        dimPulses(4);
        tick(2);
        fault(1'b1, "dim open");
        feedbackLow = 1'b0;
        restart();
        fault(1'b0, "startup clears");
        check(ledEnable, 1'b1, "startup led");
        switchRequest = 1'b1;
        tick(OT - 8);
        fault(1'b0, "on-time short");
        tick(12);
        fault(1'b1, "on-time long");
        restart();
        fault(1'b0, "second startup");
        give_verdict();
    end
endmodule : led_driver_fault_supervisor_tb

// file: lfs_host_model.sv
// Host side of the open-drain fault line
`timescale 1ns/1ps
module lfs_host_model (
    input wire logic faultReportNOut,
    input wire logic faultReportNOe,
    output logic faultWire
);
    // ------------------------------------------------------------
    // Line level
    // ------------------------------------------------------------
    // The host pull-up holds the line high unless the device enables its output; then the line follows faultReportNOut
    assign faultWire = faultReportNOe ? faultReportNOut : 1'b1;
endmodule : lfs_host_model

// file: lfs_pkg.sv
// Shared constants for the LED driver fault supervisor
package lfs_pkg;
    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int OCP_OFF_US = 1000;
    localparam int QUIET_MS = 10;
    localparam int DEGLITCH_NS = 25000;
    localparam int ONTIME_MAX_NS = 20000;
    // Shutdown low interval is not given; plain default
    localparam int SHUTDOWN_US = 20000;
    localparam int OCP_OFF_CYCLES = (OCP_OFF_US * 1000) / CLK_PERIOD_NS;
    localparam int QUIET_CYCLES = (QUIET_MS * 1000000) / CLK_PERIOD_NS;
    localparam int DEGLITCH_CYCLES = (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ONTIME_CYCLES = ONTIME_MAX_NS / CLK_PERIOD_NS;
    localparam int SHUTDOWN_CYCLES = (SHUTDOWN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DIM_CYCLES = 128;
    // ------------------------------------------------------------
    // Timer slots
    // ------------------------------------------------------------
    localparam int T_OCP_OFF = 0;
    localparam int T_OCP_QUIET = 1;
    localparam int T_OVP_QUIET = 2;
    localparam int T_OPEN_DET = 3;
    localparam int T_OPEN_QUIET = 4;
    localparam int T_DEGLITCH = 5;
    localparam int T_SHUTDOWN = 6;
    localparam int T_ONTIME = 7;
    localparam int NUM_TIMERS = 8;
    // ------------------------------------------------------------
    // Power state
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        LFS_RUN = 2'h0,
        LFS_SHDN = 2'h1,
        LFS_START = 2'h3
    } lfs_power_e;
endpackage : lfs_pkg

// file: lfs_supervisor.sv
// Fault supervisor top: switch gating, fault qualification and fault line
// Functional notes
// - An overcurrent trip while the switch is on turns it off at once, holds it off, retries.
// - Over-temperature stops switching, cuts LED current and pulls the fault line low.
// - After thermal shutdown the device restarts on cool-down and releases the line then.
// - All faults share one active-low open-drain line that only ever pulls low.
// - Shorted-inductor type trips retry after 1 ms and the line falls on the second trip.
// - The overcurrent fault is released only after 10 ms with no further trip.
// - Feedback overvoltage stops the switch, turns the string off, pulls the line at once.
// - Overvoltage clears once feedback is below 1.55 V and the line frees 10 ms later.
// - Undimmed, 10 ms of continuous low average feedback declares an LED-open fault.
// - Dimmed, 25 us deglitch plus 128 low dim cycles, or an over-long on-time, is LED-open.
// - LED-open clears after 10 ms of feedback back at regulation level.
// - A long low dimming input enters shutdown and the next high runs a full startup.
`timescale 1ns/1ps
module lfs_supervisor #(
    parameter int OCP_OFF_CYC = lfs_pkg::OCP_OFF_CYCLES,
    parameter int QUIET_CYC = lfs_pkg::QUIET_CYCLES,
    parameter int SHUTDOWN_CYC = lfs_pkg::SHUTDOWN_CYCLES,
    parameter int DEGLITCH_CYC = lfs_pkg::DEGLITCH_CYCLES,
    parameter int ONTIME_CYC = lfs_pkg::ONTIME_CYCLES,
    parameter int DIM_CYC = lfs_pkg::DIM_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic dimInput,
    input wire logic dimmingMode,
    input wire logic switchRequest,
    input wire logic overcurrentTrip,
    input wire logic feedbackOver,
    input wire logic feedbackBelowClear,
    input wire logic feedbackLow,
    input wire logic overTemp,
    input wire logic coolDown,
    input wire logic faultReportNIn,
    output logic faultReportNOut,
    output logic faultReportNOe,
    output logic highSideOn,
    output logic ledEnable
);
    localparam int NT = lfs_pkg::NUM_TIMERS;
    localparam int DW = $clog2(DIM_CYC + 1);
    localparam logic [DW-1:0] DIM_LAST = DW'(DIM_CYC);
    localparam int CNT [NT] = '{OCP_OFF_CYC, QUIET_CYC, QUIET_CYC, QUIET_CYC,
                                QUIET_CYC, DEGLITCH_CYC, SHUTDOWN_CYC, ONTIME_CYC};

    initial
    begin
        if (DIM_CYC < 1)
            $error("lfs_supervisor: DIM_CYC must be at least 1");
    end

    // ------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------
    logic timerRun [NT];
    logic timerDone [NT];

    for (genvar g = 0; g < NT; g++)
    begin : gTimer
        lfs_tmr_if tIf ();
        assign tIf.run = timerRun[g];
        assign timerDone[g] = tIf.done;
        lfs_timer #(.COUNT(CNT[g])) uTimer (
            .clk(clk),
            .sys_rst(sys_rst),
            .tmr(tIf)
        );
    end

    // ------------------------------------------------------------
    // Fault state
    // ------------------------------------------------------------
    lfs_pkg::lfs_power_e power;
    lfs_pkg::lfs_power_e next_power;
    logic ocpHold, next_ocpHold;
    logic ocpSeen, next_ocpSeen;
    logic ocpFault, next_ocpFault;
    logic ovpFault, next_ovpFault;
    logic openFault, next_openFault;
    logic thermFault, next_thermFault;
    logic dimPrev, next_dimPrev;
    logic [DW-1:0] dimCount, next_dimCount;
    logic next_highSideOn, next_ledEnable, next_faultReportNOe;
    logic trip, startClear;

    // A trip only counts while the switch actually conducts
    assign trip = overcurrentTrip && highSideOn;
    assign startClear = (power == lfs_pkg::LFS_START);

    always_comb
    begin
        timerRun[lfs_pkg::T_OCP_OFF] = ocpHold;
        timerRun[lfs_pkg::T_OCP_QUIET] = ocpSeen && !overcurrentTrip;
        timerRun[lfs_pkg::T_OVP_QUIET] = ovpFault && feedbackBelowClear;
        timerRun[lfs_pkg::T_OPEN_DET] = !dimmingMode && feedbackLow && ledEnable;
        timerRun[lfs_pkg::T_OPEN_QUIET] = openFault && !feedbackLow;
        timerRun[lfs_pkg::T_DEGLITCH] = dimmingMode && feedbackLow;
        timerRun[lfs_pkg::T_SHUTDOWN] = !dimInput;
        timerRun[lfs_pkg::T_ONTIME] = dimmingMode && highSideOn;
    end

    always_comb
    begin
        next_power = power;
        next_ocpHold = ocpHold;
        next_ocpSeen = ocpSeen;
        next_ocpFault = ocpFault;
        next_ovpFault = ovpFault;
        next_openFault = openFault;
        next_thermFault = thermFault;
        next_dimPrev = dimInput;
        next_dimCount = dimCount;

        case (power)
            lfs_pkg::LFS_RUN:
                if (timerDone[lfs_pkg::T_SHUTDOWN])
                    next_power = lfs_pkg::LFS_SHDN;
            lfs_pkg::LFS_SHDN:
                if (dimInput)
                    next_power = lfs_pkg::LFS_START;
            lfs_pkg::LFS_START:
                next_power = lfs_pkg::LFS_RUN;
            default:
                next_power = lfs_pkg::LFS_RUN;
        endcase

        // Clears are written first so that a set in the same cycle wins
        if (timerDone[lfs_pkg::T_OCP_OFF])
            next_ocpHold = 1'b0;
        if (timerDone[lfs_pkg::T_OCP_QUIET])
        begin
            next_ocpSeen = 1'b0;
            next_ocpFault = 1'b0;
        end
        if (trip)
        begin
            next_ocpHold = 1'b1;
            next_ocpSeen = 1'b1;
            if (ocpSeen)
                next_ocpFault = 1'b1;
        end

        if (timerDone[lfs_pkg::T_OVP_QUIET])
            next_ovpFault = 1'b0;
        if (feedbackOver)
            next_ovpFault = 1'b1;

        // Dim cycles of low feedback after the deglitch window
        if (!timerDone[lfs_pkg::T_DEGLITCH])
            next_dimCount = '0;
        else if (dimInput && !dimPrev && dimCount != DIM_LAST)
            next_dimCount = dimCount + DW'(1);

        if (timerDone[lfs_pkg::T_OPEN_QUIET])
            next_openFault = 1'b0;
        if (timerDone[lfs_pkg::T_OPEN_DET])
            next_openFault = 1'b1;
        if (dimCount == DIM_LAST || timerDone[lfs_pkg::T_ONTIME])
            next_openFault = 1'b1;

        if (coolDown && !overTemp)
            next_thermFault = 1'b0;
        if (overTemp)
            next_thermFault = 1'b1;

        // Leaving shutdown is a fresh power-up of the supervisor
        if (startClear)
        begin
            next_ocpHold = 1'b0;
            next_ocpSeen = 1'b0;
            next_ocpFault = 1'b0;
            next_ovpFault = feedbackOver;
            next_openFault = 1'b0;
            next_thermFault = overTemp;
            next_dimCount = '0;
        end

        next_highSideOn = switchRequest && dimInput && (power == lfs_pkg::LFS_RUN)
                          && !ocpHold && !trip
                          && !feedbackOver
                          && !thermFault && !overTemp
                          && !openFault && !next_openFault;
        next_ledEnable = dimInput && (power == lfs_pkg::LFS_RUN)
                         && !thermFault && !ovpFault && !openFault;
        next_faultReportNOe = next_ocpFault || next_ovpFault || next_openFault
                              || next_thermFault;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            power <= lfs_pkg::LFS_RUN;
            ocpHold <= 1'b0;
            ocpSeen <= 1'b0;
            ocpFault <= 1'b0;
            ovpFault <= 1'b0;
            openFault <= 1'b0;
            thermFault <= 1'b0;
            dimPrev <= 1'b0;
            dimCount <= '0;
            highSideOn <= 1'b0;
            ledEnable <= 1'b0;
            faultReportNOe <= 1'b0;
            faultReportNOut <= 1'b0;
        end
        else
        begin
            power <= next_power;
            ocpHold <= next_ocpHold;
            ocpSeen <= next_ocpSeen;
            ocpFault <= next_ocpFault;
            ovpFault <= next_ovpFault;
            openFault <= next_openFault;
            thermFault <= next_thermFault;
            dimPrev <= next_dimPrev;
            dimCount <= next_dimCount;
            highSideOn <= next_highSideOn;
            ledEnable <= next_ledEnable;
            faultReportNOe <= next_faultReportNOe;
            faultReportNOut <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_startup;
        (power == lfs_pkg::LFS_START) ##1 (power == lfs_pkg::LFS_RUN);
    endsequence

    property p_ocp_off;
        @(posedge clk) disable iff (sys_rst) trip |=> !highSideOn [*2];
    endproperty
    a_ocp_off: assert property (p_ocp_off) else $error("switch not held off on trip");

    property p_therm;
        @(posedge clk) disable iff (sys_rst)
            overTemp && !startClear |=> (thermFault && faultReportNOe && !highSideOn) ##1 !ledEnable;
    endproperty
    a_therm: assert property (p_therm) else $error("thermal shutdown incomplete");

    property p_cool;
        @(posedge clk) disable iff (sys_rst)
            $fell(thermFault) |-> $past(coolDown) || $past(startClear);
    endproperty
    a_cool: assert property (p_cool) else $error("thermal fault left without cool-down");

    property p_open_drain;
        @(posedge clk) disable iff (sys_rst) !faultReportNOut;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("fault line driven high");

    property p_second_trip;
        @(posedge clk) disable iff (sys_rst)
            trip && ocpSeen && !startClear |=> ocpFault && faultReportNOe;
    endproperty
    a_second_trip: assert property (p_second_trip) else $error("no report on second trip");

    property p_first_trip;
        @(posedge clk) disable iff (sys_rst)
            trip && !ocpSeen && !ocpFault |=> !ocpFault;
    endproperty
    a_first_trip: assert property (p_first_trip) else $error("report on first trip");

    property p_ocp_release;
        @(posedge clk) disable iff (sys_rst)
            $fell(ocpFault) |-> $past(timerDone[lfs_pkg::T_OCP_QUIET]) || $past(startClear);
    endproperty
    a_ocp_release: assert property (p_ocp_release) else $error("early overcurrent release");

    property p_ovp;
        @(posedge clk) disable iff (sys_rst)
            feedbackOver |=> (faultReportNOe && !highSideOn) ##1 !ledEnable;
    endproperty
    a_ovp: assert property (p_ovp) else $error("overvoltage not handled");

    property p_ovp_release;
        @(posedge clk) disable iff (sys_rst)
            $fell(ovpFault) |-> $past(timerDone[lfs_pkg::T_OVP_QUIET]) || $past(startClear);
    endproperty
    a_ovp_release: assert property (p_ovp_release) else $error("early overvoltage release");

    property p_open_set;
        @(posedge clk) disable iff (sys_rst)
            $rose(openFault) |-> $past(timerDone[lfs_pkg::T_OPEN_DET])
                || $past(dimCount == DIM_LAST) || $past(timerDone[lfs_pkg::T_ONTIME]);
    endproperty
    a_open_set: assert property (p_open_set) else $error("LED-open without cause");

    property p_open_clear;
        @(posedge clk) disable iff (sys_rst)
            $fell(openFault) |-> $past(timerDone[lfs_pkg::T_OPEN_QUIET]) || $past(startClear);
    endproperty
    a_open_clear: assert property (p_open_clear) else $error("early LED-open release");

    property p_wake;
        @(posedge clk) disable iff (sys_rst)
            (power == lfs_pkg::LFS_SHDN) && dimInput |=> s_startup;
    endproperty
    a_wake: assert property (p_wake) else $error("no full startup after shutdown");
endmodule : lfs_supervisor

// file: lfs_timer.sv
// Restartable qualification timer
`timescale 1ns/1ps
module lfs_timer #(
    parameter int COUNT = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    lfs_tmr_if.timer tmr
);
    localparam int W = $clog2(COUNT + 1);
    localparam logic [W-1:0] LAST = W'(COUNT);

    initial
    begin
        if (COUNT < 1)
            $error("lfs_timer: COUNT must be at least 1");
    end

    logic [W-1:0] count;
    logic [W-1:0] next_count;
    logic doneFlag;
    logic next_doneFlag;

    // Any drop of the qualifier restarts the interval
    always_comb
    begin
        next_count = '0;
        next_doneFlag = 1'b0;
        if (tmr.run)
        begin
            next_count = (count == LAST) ? count : count + W'(1);
            next_doneFlag = (next_count == LAST);
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            count <= '0;
            doneFlag <= 1'b0;
        end
        else
        begin
            count <= next_count;
            doneFlag <= next_doneFlag;
        end
    end

    assign tmr.done = doneFlag;

    property p_restart;
        @(posedge clk) disable iff (sys_rst) !tmr.run |=> (count == '0) && !tmr.done;
    endproperty
    a_restart: assert property (p_restart) else $error("timer did not restart");
endmodule : lfs_timer

// file: lfs_tmr_if.sv
// Run/expiry handshake between the supervisor and one fault timer
`timescale 1ns/1ps
interface lfs_tmr_if;
    logic run;
    logic done;
    modport timer (input run, output done);
    modport user (output run, input done);
endinterface : lfs_tmr_if
